// ==== core/smm_sequencer.v ====
`timescale 1ns/1ps
`include "smm_defs.vh"

module smm_sequencer
#(
	parameter TICK_CYCLES = `SMM_TICK_NS / `SMM_CLK_NS
)
(
	// clock and reset
	input wire clk,
	input wire reset,
	// configuration
	input wire [1:0] mode,
	input wire [1:0] direction,
	input wire with_enable,
	input wire enable_only,
	input wire closing_sensor,
	input wire blind_en,
	input wire [9:0] blind_ms,
	input wire [12:0] sensor_time_ms,
	input wire min_sensor_time_en,
	input wire [12:0] end_muting_ms,
	input wire [7:0] timeout_sec,
	input wire timeout_unlimited,
	// field inputs
	input wire muting_sensor_a,
	input wire muting_sensor_b,
	input wire muting_sensor_c,
	input wire muting_sensor_d,
	input wire safety_in,
	input wire enable_in,
	// results
	output reg safety_out_q,
	output reg muting_active_q,
	output reg blind_active_q,
	output reg timeout_flag_q,
	output reg refused_flag_q
);

	// ****************************************************************
	// states
	// ****************************************************************
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_READY = 3'h1;
	localparam [2:0] ST_PAIR = 3'h2;
	localparam [2:0] ST_MUTE = 3'h4;
	localparam [2:0] ST_BLIND = 3'h5;
	localparam [2:0] ST_REFUSE = 3'h6;

	reg [2:0] state_q;
	reg [2:0] state_d;
	reg dir_up_q;
	reg dir_up_d;
	reg en_prev_q;
	reg arm_q;
	reg safe_prev_q;
	reg third_seen_q;
	reg rel_q;
	wire tick;
	wire [3:0] tmr_clr;
	wire [3:0] tmr_exp;
	wire [4*`SMM_TW-1:0] tmr_lim;

	// ****************************************************************
	// clamp configured times into their legal ranges
	// ****************************************************************
	function [`SMM_TW-1:0] clamp;
		input [`SMM_TW-1:0] v;
		input [`SMM_TW-1:0] lo;
		input [`SMM_TW-1:0] hi;
		begin
			clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
		end
	endfunction

	wire [`SMM_TW-1:0] sens_lim = clamp({7'h00, sensor_time_ms}, `SMM_SENS_MIN_MS,
		`SMM_SENS_MAX_MS);
	wire [`SMM_TW-1:0] blind_lim = clamp({10'h000, blind_ms}, `SMM_BLIND_MIN_MS,
		`SMM_BLIND_MAX_MS);
	wire [`SMM_TW-1:0] end_lim = clamp({7'h00, end_muting_ms}, `SMM_END_MIN_MS,
		`SMM_END_MAX_MS);
	wire [7:0] tmo_s = (timeout_sec < `SMM_TMO_MIN_S) ? `SMM_TMO_MIN_S : timeout_sec;
	wire [27:0] tmo_prod = tmo_s * `SMM_MS_PER_S;
	wire [`SMM_TW-1:0] tmo_lim = tmo_prod[`SMM_TW-1:0];

	// ****************************************************************
	// decoded conditions
	// ****************************************************************
	wire m_l = (mode == `SMM_MODE_L);
	wire m_seq = (mode == `SMM_MODE_SEQ);
	wire up_ok = (direction != `SMM_DIR_DOWN) || m_l;
	wire down_ok = (direction != `SMM_DIR_UP) && !m_l;
	wire en_rise = enable_in & ~en_prev_q;
	wire en_fall = ~enable_in & en_prev_q;
	wire cancel = with_enable & ~enable_only & en_fall;
	wire armed = ~with_enable | (arm_q & ~cancel);
	wire ab_clear = ~muting_sensor_a & ~muting_sensor_b;
	wire cd_clear = ~muting_sensor_c & ~muting_sensor_d;
	wire pre_ok = safety_in & ab_clear & (m_l | cd_clear);
	wire pair_both = dir_up_q ? (muting_sensor_a & muting_sensor_b) :
		(muting_sensor_c & muting_sensor_d);
	wire pair_any = dir_up_q ? (muting_sensor_a | muting_sensor_b) :
		(muting_sensor_c | muting_sensor_d);
	wire third = dir_up_q ? muting_sensor_c : muting_sensor_b;
	wire curtain_rise = safety_in & ~safe_prev_q;
	wire blind_use = blind_en & (m_l | ~closing_sensor);
	wire spacing_ok = ~min_sensor_time_en | m_l | m_seq | tmr_exp[`SMM_T_SPC];
	wire tmo_hit = tmr_exp[`SMM_T_TMO] & ~timeout_unlimited;
	reg close_now;

	// ****************************************************************
	// cycle sequencing
	// ****************************************************************
	always @*
	begin
		state_d = state_q;
		dir_up_d = dir_up_q;
		close_now = 1'b0;
		case (state_q)
			ST_IDLE:
			begin
				// a cycle may only begin from a clear gap
				if (pre_ok)
					state_d = ST_READY;
			end
			ST_READY:
			begin
				if (!safety_in)
					state_d = ST_IDLE;
				else if (up_ok && (m_seq ? (muting_sensor_a && !muting_sensor_b) :
					!ab_clear) && cd_clear)
				begin
					state_d = ST_PAIR;
					dir_up_d = 1'b1;
				end
				else if (down_ok && (m_seq ? (muting_sensor_d && !muting_sensor_c) :
					!cd_clear) && ab_clear)
				begin
					state_d = ST_PAIR;
					dir_up_d = 1'b0;
				end
				else if (!(ab_clear && cd_clear))
					state_d = ST_REFUSE;
			end
			ST_PAIR:
			begin
				if (!pair_any)
					state_d = ST_IDLE;
				else if (pair_both)
				begin
					// second sensor arrived: check window, spacing and arming
					if (!m_seq && tmr_exp[`SMM_T_WIN])
						state_d = ST_REFUSE;
					else if (spacing_ok && armed && safety_in)
						state_d = ST_MUTE;
					else
						state_d = ST_REFUSE;
				end
				else if (!m_seq && tmr_exp[`SMM_T_WIN])
					state_d = ST_REFUSE;
			end
			ST_MUTE:
			begin
				if (tmo_hit || cancel)
					state_d = ST_IDLE;
				else if (m_l)
					close_now = rel_q & tmr_exp[`SMM_T_END];
				else if (closing_sensor)
					close_now = third_seen_q & ~third;
				else
					close_now = curtain_rise;
				if (close_now && !tmo_hit && !cancel)
					state_d = blind_use ? ST_BLIND : ST_IDLE;
			end
			ST_BLIND:
			begin
				if (cancel)
					state_d = ST_IDLE;
				else if (tmr_exp[`SMM_T_END])
					state_d = ST_IDLE;
			end
			ST_REFUSE:
			begin
				// sit out the bad sequence until the gap is clear
				if (ab_clear && cd_clear)
					state_d = ST_IDLE;
			end
			default:
				state_d = ST_IDLE;
		endcase
	end

	// ****************************************************************
	// timers: window, spacing, timeout, end-of-muting or blind
	// ****************************************************************
	assign tmr_clr[`SMM_T_WIN] = (state_q != ST_PAIR);
	assign tmr_clr[`SMM_T_SPC] = (state_q != ST_PAIR);
	assign tmr_clr[`SMM_T_TMO] = (state_q != ST_MUTE);
	// restart on every state change so blind time starts from zero
	assign tmr_clr[`SMM_T_END] = (state_d != state_q) ||
		!((state_q == ST_BLIND) || ((state_q == ST_MUTE) && m_l && rel_q));
	assign tmr_lim[`SMM_T_WIN*`SMM_TW +: `SMM_TW] = sens_lim;
	assign tmr_lim[`SMM_T_SPC*`SMM_TW +: `SMM_TW] = `SMM_SPACING_MS;
	assign tmr_lim[`SMM_T_TMO*`SMM_TW +: `SMM_TW] = tmo_lim;
	assign tmr_lim[`SMM_T_END*`SMM_TW +: `SMM_TW] = (state_q == ST_BLIND) ? blind_lim :
		end_lim;

	smm_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick
	(
		.clk(clk),
		.reset(reset),
		.tick_q(tick)
	);

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1)
		begin : g_tmr
			smm_timer u_tmr
			(
				.clk(clk),
				.reset(reset),
				.tick(tick),
				.clear(tmr_clr[gi]),
				.limit(tmr_lim[gi*`SMM_TW +: `SMM_TW]),
				.expired(tmr_exp[gi])
			);
		end
	endgenerate

	// ****************************************************************
	// enable arming, a rise arms one cycle
	// ****************************************************************
	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			en_prev_q <= 1'b1;
			arm_q <= 1'b0;
		end
		else
		begin
			en_prev_q <= enable_in;
			// a fresh rise wins over consumption in the same cycle
			if (en_rise)
				arm_q <= 1'b1;
			else if (cancel || (state_d == ST_MUTE && state_q != ST_MUTE))
				arm_q <= 1'b0;
		end
	end

	// ****************************************************************
	// cycle bookkeeping
	// ****************************************************************
	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			state_q <= ST_IDLE;
			dir_up_q <= 1'b1;
			safe_prev_q <= 1'b0;
			third_seen_q <= 1'b0;
			rel_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			dir_up_q <= dir_up_d;
			safe_prev_q <= safety_in;
			if (state_q != ST_MUTE)
			begin
				third_seen_q <= 1'b0;
				rel_q <= 1'b0;
			end
			else
			begin
				if (third)
					third_seen_q <= 1'b1;
				if (!(muting_sensor_a && muting_sensor_b))
					rel_q <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// outputs; registered from state_d, so in step with state, one cycle behind the inputs
	// ****************************************************************
	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			safety_out_q <= 1'b0;
			muting_active_q <= 1'b0;
			blind_active_q <= 1'b0;
			timeout_flag_q <= 1'b0;
			refused_flag_q <= 1'b0;
		end
		else
		begin
			safety_out_q <= safety_in || (state_d == ST_MUTE) ||
				(state_d == ST_BLIND);
			muting_active_q <= (state_d == ST_MUTE);
			blind_active_q <= (state_d == ST_BLIND);
			// flags stand until the next muting cycle begins
			if (state_q == ST_MUTE && tmo_hit)
				timeout_flag_q <= 1'b1;
			else if (state_d == ST_MUTE && state_q != ST_MUTE)
				timeout_flag_q <= 1'b0;
			if (state_d == ST_REFUSE)
				refused_flag_q <= 1'b1;
			else if (state_d == ST_MUTE && state_q != ST_MUTE)
				refused_flag_q <= 1'b0;
		end
	end

endmodule

// ==== include/smm_defs.vh ====
`ifndef SMM_DEFS_VH
`define SMM_DEFS_VH

// ****************************************************************
// clock and tick
// ****************************************************************
`define SMM_CLK_NS 10
`define SMM_TICK_NS 1000000
`define SMM_TW 20
`define SMM_TICKW 17

// ****************************************************************
// sensor logic modes
// ****************************************************************
`define SMM_MODE_CONC 2'h0
`define SMM_MODE_L 2'h1
`define SMM_MODE_SEQ 2'h2

// ****************************************************************
// travel directions
// ****************************************************************
`define SMM_DIR_BOTH 2'h0
`define SMM_DIR_UP 2'h1
`define SMM_DIR_DOWN 2'h2

// ****************************************************************
// time limits in ms (timeout in s)
// ****************************************************************
`define SMM_SENS_MIN_MS 20'h007D0
`define SMM_SENS_MAX_MS 20'h01388
`define SMM_SPACING_MS 20'h00096
`define SMM_BLIND_MIN_MS 20'h000FA
`define SMM_BLIND_MAX_MS 20'h003E8
`define SMM_END_MIN_MS 20'h009C4
`define SMM_END_MAX_MS 20'h01770
`define SMM_TMO_MIN_S 8'h0A
`define SMM_MS_PER_S 20'h003E8

// ****************************************************************
// timer slots
// ****************************************************************
`define SMM_T_WIN 0
`define SMM_T_SPC 1
`define SMM_T_TMO 2
`define SMM_T_END 3

`endif

// ==== core/smm_tick.v ====
`timescale 1ns/1ps
`include "smm_defs.vh"

module smm_tick
#(
	parameter TICK_CYCLES = `SMM_TICK_NS / `SMM_CLK_NS
)
(
	// clock and reset
	input wire clk,
	input wire reset,
	// one-cycle pulse per period
	output reg tick_q
);

	reg [`SMM_TICKW-1:0] cnt_q;

	// free running divider, one pulse every TICK_CYCLES clocks
	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			cnt_q <= {`SMM_TICKW{1'b0}};
			tick_q <= 1'b0;
		end
		else if (cnt_q == TICK_CYCLES[`SMM_TICKW-1:0] - 1'b1)
		begin
			cnt_q <= {`SMM_TICKW{1'b0}};
			tick_q <= 1'b1;
		end
		else
		begin
			cnt_q <= cnt_q + 1'b1;
			tick_q <= 1'b0;
		end
	end

endmodule

// ==== core/smm_timer.v ====
`timescale 1ns/1ps
`include "smm_defs.vh"

module smm_timer
(
	// clock and reset
	input wire clk,
	input wire reset,
	// control
	input wire tick,
	input wire clear,
	input wire [`SMM_TW-1:0] limit,
	// status
	output wire expired
);

	reg [`SMM_TW-1:0] cnt_q;

	// saturating ms counter, held at zero while cleared
	always @(posedge clk or posedge reset)
	begin
		if (reset)
			cnt_q <= {`SMM_TW{1'b0}};
		else if (clear)
			cnt_q <= {`SMM_TW{1'b0}};
		else if (tick && !expired)
			cnt_q <= cnt_q + 1'b1;
	end

	assign expired = (cnt_q >= limit);

endmodule

// ==== test/smm_checker_assertions.sv ====
`timescale 1ns/1ps
`include "smm_defs.vh"
// ****************************************************************
// port-level checks of the muting sequencer
// ****************************************************************
module smm_checker
(
	// clock and reset
	input wire clk,
	input wire reset,
	// configuration
	input wire [1:0] mode,
	input wire with_enable,
	input wire enable_only,
	input wire closing_sensor,
	// field inputs
	input wire muting_sensor_a,
	input wire muting_sensor_b,
	input wire muting_sensor_c,
	input wire muting_sensor_d,
	input wire safety_in,
	input wire enable_in,
	// results
	input wire safety_out_q,
	input wire muting_active_q,
	input wire blind_active_q,
	input wire timeout_flag_q
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (reset);
	// muting entered on this edge
	sequence s_start;
		$rose(muting_active_q);
	endsequence
	// a whole pair was held when the start was taken
	sequence s_pair;
		$past(muting_sensor_a && muting_sensor_b || muting_sensor_c && muting_sensor_d);
	endsequence
	// skip the first edge after reset: outputs still hold reset values
	AST_OUT_FOLLOWS: assert property (
		!$past(reset) |-> safety_out_q == (muting_active_q | blind_active_q | $past(safety_in)))
		else $error("output does not follow input");
	AST_START_PAIR: assert property (
		s_start ##0 mode != `SMM_MODE_L |-> s_pair) else $error("start without pair");
	AST_START_FREE: assert property (
		s_start |-> $past(safety_in)) else $error("start with curtain blocked");
	AST_L_PAIR: assert property (
		s_start ##0 mode == `SMM_MODE_L |-> $past(muting_sensor_a && muting_sensor_b))
		else $error("L start without a and b");
	AST_TIMEOUT_STOP: assert property (
		$rose(timeout_flag_q) |-> !muting_active_q && !blind_active_q && $past(muting_active_q))
		else $error("timeout did not stop muting");
	AST_ENABLE_DROP: assert property (
		with_enable && !enable_only && $fell(enable_in) |=> !muting_active_q && !blind_active_q)
		else $error("enable fall kept muting");
	AST_ENABLE_ONLY: assert property (
		with_enable && enable_only && muting_active_q && $fell(enable_in) && !safety_in
		&& !closing_sensor && mode != `SMM_MODE_L |=> muting_active_q || timeout_flag_q)
		else $error("enable-only fall cancelled muting");
	AST_CURTAIN_END: assert property (
		muting_active_q && !closing_sensor && mode != `SMM_MODE_L && $rose(safety_in)
		|=> !muting_active_q) else $error("curtain rise did not close");
	AST_BLIND_AFTER: assert property (
		$rose(blind_active_q) |-> $past(muting_active_q) && (mode == `SMM_MODE_L || !closing_sensor))
		else $error("blind without curtain closing");
endmodule
bind smm_sequencer smm_checker smm_checker_inst (.clk(clk), .reset(reset), .mode(mode),
	.with_enable(with_enable), .enable_only(enable_only), .closing_sensor(closing_sensor),
	.muting_sensor_a(muting_sensor_a), .muting_sensor_b(muting_sensor_b),
	.muting_sensor_c(muting_sensor_c), .muting_sensor_d(muting_sensor_d),
	.safety_in(safety_in), .enable_in(enable_in), .safety_out_q(safety_out_q),
	.muting_active_q(muting_active_q), .blind_active_q(blind_active_q),
	.timeout_flag_q(timeout_flag_q));

// ==== test/smm_pallet.sv ====
`timescale 1ns/1ps
// ****************************************************************
// pallet crossing the guarded opening
// ****************************************************************
module smm_pallet
(
	// travel stage and direction
	input wire [3:0] pos,
	input wire down,
	// sensors and curtain
	output wire muting_sensor_a,
	output wire muting_sensor_b,
	output wire muting_sensor_c,
	output wire muting_sensor_d,
	output wire safety_in
);
	reg [4:0] v;
	// {a,b,c,d,curtain free} per stage; curtain blocked only inside the opening
	always @*
	begin
		case (pos)
			4'h1: v = 5'h11;
			4'h2: v = 5'h19;
			4'h3: v = 5'h18;
			4'h4: v = 5'h1E;
			4'h5: v = 5'h0E;
			4'h6: v = 5'h06;
			4'h7: v = 5'h07;
			4'h8: v = 5'h03;
			default: v = 5'h01;
		endcase
	end
	// reverse travel mirrors the sensor row
	assign {muting_sensor_a, muting_sensor_b, muting_sensor_c, muting_sensor_d} =
		down ? {v[1], v[2], v[3], v[4]} : v[4:1];
	assign safety_in = v[0];
endmodule

// ==== test/safety_muting_sequencer_test.sv ====
`timescale 1ns/1ps
`include "smm_defs.vh"
module safety_muting_sequencer_test;
	reg clk = 0, reset = 1, with_enable = 0, enable_only = 0, closing_sensor = 0, blind_en = 1;
	reg min_sensor_time_en = 0, timeout_unlimited = 0, enable_in = 0, down = 0;
	reg [1:0] mode = 0, direction = 0;
	reg [7:0] timeout_sec = 8'h0A;
	reg [3:0] pos = 0;
	wire [9:0] blind_ms = 10'h0FA;
	wire [12:0] sensor_time_ms = 13'h07D0;
	wire [12:0] end_muting_ms = 13'h09C4;
	wire muting_sensor_a, muting_sensor_b, muting_sensor_c, muting_sensor_d, safety_in;
	wire safety_out_q, muting_active_q, blind_active_q, timeout_flag_q, refused_flag_q;
	integer fails = 0, checks = 0, n;
	// one tick per clock keeps the whole run short
	smm_sequencer #(.TICK_CYCLES(1)) smm_sequencer_inst (.clk(clk), .reset(reset), .mode(mode),
		.direction(direction), .with_enable(with_enable), .enable_only(enable_only),
		.closing_sensor(closing_sensor), .blind_en(blind_en), .blind_ms(blind_ms),
		.sensor_time_ms(sensor_time_ms), .min_sensor_time_en(min_sensor_time_en),
		.end_muting_ms(end_muting_ms), .timeout_sec(timeout_sec),
		.timeout_unlimited(timeout_unlimited), .muting_sensor_a(muting_sensor_a),
		.muting_sensor_b(muting_sensor_b), .muting_sensor_c(muting_sensor_c),
		.muting_sensor_d(muting_sensor_d), .safety_in(safety_in), .enable_in(enable_in),
		.safety_out_q(safety_out_q), .muting_active_q(muting_active_q),
		.blind_active_q(blind_active_q), .timeout_flag_q(timeout_flag_q),
		.refused_flag_q(refused_flag_q));
	smm_pallet smm_pallet_inst (.pos(pos), .down(down), .muting_sensor_a(muting_sensor_a),
		.muting_sensor_b(muting_sensor_b), .muting_sensor_c(muting_sensor_c),
		.muting_sensor_d(muting_sensor_d), .safety_in(safety_in));
	always #5 clk = ~clk;
	// ****************************************************************
	// helpers
	// ****************************************************************
	task chk(input [8*6-1:0] nm, input seen, input exp);
	begin
		checks = checks + 1;
		if (seen !== exp)
		begin
			fails = fails + 1;
			$display("BAD %0s exp %b seen %b", nm, exp, seen);
		end
	end
	endtask
	task report_and_stop;
	begin
		if (fails == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	end
	endtask
	task go(input [3:0] p, input integer k);
	begin
		pos = p;
		repeat (k) @(negedge clk);
	end
	endtask
	// clear, first sensor, gap, then the second of the pair
	task enter(input integer gap);
	begin
		go(0, 4);
		go(1, gap);
		go(2, 3);
	end
	endtask
	// block the curtain, then let it rise again
	task leave;
	begin
		go(3, 3);
		go(7, 3);
		go(0, 4);
	end
	endtask
	// bounded wait for muting (0) or blind (1) to drop
	task wait_low(input sel, input integer lim);
	begin
		n = 0;
		while ((sel ? blind_active_q : muting_active_q) !== 1'b0 && n < lim)
		begin
			@(negedge clk);
			n = n + 1;
		end
		if (n >= lim)
		begin
			chk("hang", 1'b0, 1'b1);
			report_and_stop;
		end
	end
	endtask
	// ****************************************************************
	// scenarios
	// ****************************************************************
	initial
	begin
		repeat (4) @(negedge clk);
		reset = 0;
		enter(200);
		chk("mute", muting_active_q, 1);
		go(3, 3);
		chk("out", safety_out_q, 1);
		go(4, 3);
		go(6, 3);
		go(7, 3);
		chk("close", muting_active_q, 0);
		chk("blind", blind_active_q, 1);
		wait_low(1, 400);
		chk("blindt", n > 240 && n < 255, 1);
		go(3, 3);
		chk("thru", safety_out_q, 0);
		blind_en = 0;
		enter(2100);
		chk("late", muting_active_q, 0);
		chk("refuse", refused_flag_q, 1);
		min_sensor_time_en = 1;
		enter(50);
		chk("near", muting_active_q, 0);
		enter(200);
		chk("spaced", muting_active_q, 1);
		leave;
		direction = `SMM_DIR_DOWN;
		enter(200);
		chk("wrong", muting_active_q, 0);
		down = 1;
		enter(200);
		chk("down", muting_active_q, 1);
		leave;
		// reverse travel must be refused when only upward travel is allowed
		direction = `SMM_DIR_UP;
		enter(200);
		chk("upref", muting_active_q, 0);
		down = 0;
		direction = `SMM_DIR_BOTH;
		mode = `SMM_MODE_SEQ;
		enter(2100);
		chk("seq", muting_active_q, 1);
		leave;
		mode = `SMM_MODE_L;
		enter(200);
		chk("lmute", muting_active_q, 1);
		go(5, 1);
		wait_low(0, 2700);
		chk("lend", n > 2490 && n < 2510, 1);
		mode = `SMM_MODE_CONC;
		enter(200);
		go(3, 1);
		wait_low(0, 10100);
		chk("tmot", n > 9980 && n < 10010, 1);
		chk("tmo", timeout_flag_q, 1);
		// unlimited timeout: muting outlives the ten second limit
		timeout_unlimited = 1;
		enter(200);
		go(3, 10100);
		chk("nolim", muting_active_q, 1);
		// sensor closing ignores the curtain rise, ends on third sensor clear
		closing_sensor = 1;
		go(7, 3);
		chk("shold", muting_active_q, 1);
		go(8, 3);
		chk("sopen", muting_active_q, 0);
		closing_sensor = 0;
		timeout_unlimited = 0;
		with_enable = 1;
		enter(200);
		chk("stuck", muting_active_q, 0);
		enable_in = 1;
		enter(200);
		chk("armed", muting_active_q, 1);
		enable_in = 0;
		go(2, 2);
		chk("cancel", muting_active_q, 0);
		enable_only = 1;
		enable_in = 1;
		enter(200);
		go(3, 3);
		enable_in = 0;
		go(3, 3);
		chk("keep", muting_active_q, 1);
		leave;
		enter(200);
		chk("rearm", muting_active_q, 0);
		report_and_stop;
	end
endmodule
